/* lcef_ctrl.sv */
// module: led channel enable, fade ramp, pwm dimming and fault control with wishbone registers
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - momentary mode debounces and latches main enables
// - pulse mode: each low pulse toggles channel
// - level mode: high turns on, low off
// - pull-up in pulse mode, pull-down in level
// - backlight enable deglitched, level sets backlight
// - host command starts internal dimming, no pwm pin
// - enable pins override serial commands
// - on trigger ramps up in 63 gamma steps
// - trigger while on ramps down to zero
// - new trigger interrupts a running ramp
// - fault pin low on short, open, thermal
// - host sets mode, currents, fades; reads state
// - internal pwm runs near 220Hz, gamma duty
// - host serial link I2C-compatible up to 1MHz; this block has a wishbone slave port instead
// - fade up and down times set independently
// - fade-up timing grounded gives instant on
// - fade-down timing grounded gives instant off
module lcef_ctrl
	import lcef_pkg::*;
#(
	parameter int DEB_CYC = DEBOUNCE_CYC,  // main enable filter length
	parameter int GLT_CYC = DEGLITCH_CYC,  // backlight enable filter length
	parameter int PWM_CYC = PWM_PERIOD_CYC // pwm period in clocks
)(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        mainEnableA,
	input  wire logic        mainEnableB,
	input  wire logic        backlightEnable,
	input  wire logic        ledShort,
	input  wire logic        ledOpen,
	input  wire logic        thermalTrip,
	input  wire logic        fadeUpTimingGnd,
	input  wire logic        fadeDownTimingGnd,
	output logic             mainOutputA,
	output logic             mainOutputB,
	output logic             backlightOutput,
	output logic             enPullUp,
	output logic             enPullDown,
	output logic             faultFlagNOut,
	output logic             faultFlagNOe,
	output logic             irq
);
	// pwm tick divides the period into gamma slots
	// integer division makes the real period slightly shorter than asked
	// a period below the slot count clamps the tick to one clock per slot
	localparam int TICK_DIV = (PWM_CYC / int'(GAMMA_FULL)) < 1 ? 1
		: PWM_CYC / int'(GAMMA_FULL);

	// gamma table: square law over the 63 steps
	// square law keeps the low steps fine, where the eye is most sensitive
	// the last step lands exactly on the slot count, so full means always on
	function automatic logic [11:0] gamma(input logic [5:0] s);
		logic [11:0] w;
		w = {6'h00, s};
		return 12'(w * w);
	endfunction

	// byte-lane merge for wishbone writes
	// lanes with sel low keep the old register byte
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[b*8 +: 8] = dat[b*8 +: 8];
		end
		return r;
	endfunction

	logic [7:0]  syncA_q;     // first synchroniser stage
	logic [7:0]  syncB_q;     // second synchroniser stage
	logic [2:0]  db_q;        // filtered enable levels
	logic [2:0]  dbPrev_q;    // previous filtered levels
	logic [2:0]  fall;        // filtered falling edges
	lcef_ctrl_t  ctrl_q;      // mode bits
	logic [23:0] fadeUp_q;    // clocks per up step, less one
	logic [23:0] fadeDn_q;    // clocks per down step, less one
	logic [23:0] current_q;   // per-channel current codes
	logic [1:0]  cmdTog_q;    // one-cycle command triggers
	logic [2:0]  chOn_q;      // channel target state
	logic [5:0]  level_q [3]; // ramp step per channel
	logic [2:0]  busy_q;      // ramp running
	logic [2:0]  busyNow;     // ramp running this cycle
	logic [15:0] tick_q;      // pwm slot prescaler
	logic [11:0] pwm_q;       // pwm slot counter
	lcef_fault_t fault;       // synchronised fault inputs
	logic        faultPrev_q; // for the fault-raised event
	logic [3:0]  intStat_q;   // sticky events
	logic [3:0]  intMask_q;   // event enables
	logic [3:0]  events;      // event pulses
	logic        access;      // new wishbone cycle
	logic        wr;          // write strobe
	logic [31:0] rdData;      // read mux
	logic [31:0] wmData;      // merged write data base
	logic [2:0]  pwmOut_q;    // registered pwm compare

	// every pin passes two flops before any logic looks at it
	// timing straps and fault lines share the chain: they are slow levels
	// and one common latency keeps their relative order intact
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q <= 8'h00;
			syncB_q <= 8'h00;
		end else begin
			syncA_q <= {fadeDownTimingGnd, fadeUpTimingGnd, thermalTrip, ledOpen,
				ledShort, backlightEnable, mainEnableB, mainEnableA};
			syncB_q <= syncA_q;
		end
	end

	assign fault = lcef_fault_t'(syncB_q[5:3]);

	// enable filters: a level must hold for the full window to be taken
	// the counter restarts on any agreement, so bounce inside the window
	// never accumulates toward a change
	generate
		for (genvar i = 0; i < 3; i++) begin : g_filt
			localparam int LIM = (i == 2) ? GLT_CYC : DEB_CYC;
			logic [19:0] cnt_q; // stable-time counter
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cnt_q <= 20'h00000;
					db_q[i] <= 1'b0;
				end else if (syncB_q[i] == db_q[i]) begin
					cnt_q <= 20'h00000; // input agrees, restart window
				end else if (cnt_q >= 20'(LIM - 1)) begin
					cnt_q <= 20'h00000;
					db_q[i] <= syncB_q[i];
				end else begin
					cnt_q <= cnt_q + 20'h00001;
				end
			end
		end
	endgenerate

	// edge history of the filtered levels
	// one clock of delay, so an edge is seen for exactly one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) dbPrev_q <= 3'h0;
		else dbPrev_q <= db_q;
	end

	// falling edges only count once the prior level was seen high
	assign fall = dbPrev_q & ~db_q;

	// channel targets: pins first, host commands only without a pin action
	// a command in the same cycle as a pin edge is simply lost
	// level mode ignores commands altogether, the pin level is the truth
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chOn_q <= 3'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!ctrl_q.pulseMode) begin
					chOn_q[i] <= db_q[i];
				end else if (fall[i]) begin
					chOn_q[i] <= ~chOn_q[i];
				end else if (ctrl_q.intDim && cmdTog_q[i]) begin
					chOn_q[i] <= ~chOn_q[i];
				end
			end
			chOn_q[2] <= db_q[2];
		end
	end

	// fade ramp per channel; target follows chOn, so a new trigger reverses mid-ramp
	// the step counter is not cleared on reversal, so the first step
	// in the new direction may come early; it never comes late
	generate
		for (genvar i = 0; i < 3; i++) begin : g_ramp
			logic [23:0] stepCnt_q; // clocks since last step
			logic [23:0] interval;  // chosen step period
			logic        instant;   // timing input grounded
			logic [5:0]  target;    // final step
			assign interval = chOn_q[i] ? fadeUp_q : fadeDn_q;
			assign instant  = chOn_q[i] ? syncB_q[6] : syncB_q[7];
			assign target   = chOn_q[i] ? STEP_FULL : 6'h00;
			assign busyNow[i] = level_q[i] != target;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stepCnt_q <= 24'h000000;
					level_q[i] <= 6'h00;
				end else if (instant) begin
					stepCnt_q <= 24'h000000;
					level_q[i] <= target;
				end else if (!busyNow[i]) begin
					stepCnt_q <= 24'h000000;
				end else if (stepCnt_q >= interval) begin
					stepCnt_q <= 24'h000000;
					// direction is re-read every step: no waiting for ramp end
					if (chOn_q[i]) level_q[i] <= level_q[i] + 6'h01;
					else level_q[i] <= level_q[i] - 6'h01;
				end else begin
					stepCnt_q <= stepCnt_q + 24'h000001;
				end
			end
		end
	endgenerate

	// busy history for ramp-done events
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) busy_q <= 3'h0;
		else busy_q <= busyNow;
	end

	// pwm time base: period split into GAMMA_FULL slots
	// one shared counter keeps the three channels in phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 16'h0000;
			pwm_q <= 12'h000;
		end else if (tick_q >= 16'(TICK_DIV - 1)) begin
			tick_q <= 16'h0000;
			pwm_q <= (pwm_q >= GAMMA_FULL - 12'h001) ? 12'h000 : pwm_q + 12'h001;
		end else begin
			tick_q <= tick_q + 16'h0001;
		end
	end

	// gamma duty compare; step 63 stays high the whole period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwmOut_q <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				pwmOut_q[i] <= gamma(level_q[i]) > pwm_q;
			end
		end
	end

	assign mainOutputA     = pwmOut_q[0];
	assign mainOutputB     = pwmOut_q[1];
	assign backlightOutput = pwmOut_q[2];

	// pad strength select and open-drain fault drive
	// the output level is tied low and only the enable moves, so the pad
	// never pushes the line high against the board pull-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enPullUp <= 1'b1;
			enPullDown <= 1'b0;
			faultFlagNOut <= 1'b0;
			faultFlagNOe <= 1'b0;
		end else begin
			enPullUp <= ctrl_q.pulseMode;
			enPullDown <= ~ctrl_q.pulseMode;
			faultFlagNOut <= 1'b0; // open drain only ever pulls low
			faultFlagNOe <= |fault;
		end
	end

	// event sources: fault raised, ramp finished per channel
	// a fault that stays up raises one event only, on its first clock
	assign events = {busy_q & ~busyNow, (|fault) & ~faultPrev_q};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) faultPrev_q <= 1'b0;
		else faultPrev_q <= |fault;
	end

	// wishbone strobes: one access per cycle, ack follows one clock later
	// an outside serial bridge turns host link transfers into these cycles
	// the ack term blocks a second take of a held strobe
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr     = access & wb_we_i;

	// read mux; unmapped offsets read zero and are still acked
	// status is live, not latched: a fault that clears reads back clear
	always_comb begin
		rdData = 32'h00000000;
		case (wb_adr_i)
			ADR_CTRL:    rdData[1:0] = ctrl_q;
			ADR_FADEUP:  rdData[23:0] = fadeUp_q;
			ADR_FADEDN:  rdData[23:0] = fadeDn_q;
			ADR_CURRENT: rdData[23:0] = current_q;
			ADR_STATUS: begin
				rdData[ST_ON +: 3] = chOn_q;
				rdData[ST_BUSY +: 3] = busyNow;
				rdData[ST_FAULT +: 3] = fault;
				rdData[ST_DB +: 3] = db_q;
			end
			ADR_INTSTAT: rdData[3:0] = intStat_q;
			ADR_INTMASK: rdData[3:0] = intMask_q;
			default:     rdData = 32'h00000000;
		endcase
	end

	// merged base for partial writes
	always_comb begin
		wmData = 32'h00000000;
		case (wb_adr_i)
			ADR_CTRL:    wmData = merge({30'h0, ctrl_q}, wb_dat_i, wb_sel_i);
			ADR_FADEUP:  wmData = merge({8'h00, fadeUp_q}, wb_dat_i, wb_sel_i);
			ADR_FADEDN:  wmData = merge({8'h00, fadeDn_q}, wb_dat_i, wb_sel_i);
			ADR_CURRENT: wmData = merge({8'h00, current_q}, wb_dat_i, wb_sel_i);
			ADR_INTMASK: wmData = merge({28'h0, intMask_q}, wb_dat_i, wb_sel_i);
			default:     wmData = merge(32'h00000000, wb_dat_i, wb_sel_i);
		endcase
	end

	// bus answer registers
	// data is zeroed outside ack so nothing stale sits on the bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= access ? rdData : 32'h00000000;
		end
	end

	// host-writable configuration
	// current codes are stored only; no port drives them out, the bus reads them back
	// mode changes take effect at once, also in the middle of a ramp
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= lcef_ctrl_t'(CTRL_RST);
			fadeUp_q <= FADEUP_RST;
			fadeDn_q <= FADEDN_RST;
			current_q <= CURRENT_RST;
			intMask_q <= INTMASK_RST;
		end else if (wr) begin
			case (wb_adr_i)
				ADR_CTRL:    ctrl_q <= lcef_ctrl_t'(wmData[1:0]);
				ADR_FADEUP:  fadeUp_q <= wmData[23:0];
				ADR_FADEDN:  fadeDn_q <= wmData[23:0];
				ADR_CURRENT: current_q <= wmData[23:0];
				ADR_INTMASK: intMask_q <= wmData[3:0];
				default:     ctrl_q <= ctrl_q;
			endcase
		end
	end

	// host command triggers, self-clearing after one clock
	// only lane 0 carries the command bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cmdTog_q <= 2'h0;
		else if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0]) cmdTog_q <= wb_dat_i[1:0];
		else cmdTog_q <= 2'h0;
	end

	// sticky events: a set in the clearing cycle survives the clear
	// clearing is per bit, so one write can acknowledge any subset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intStat_q <= 4'h0;
		end else if (wr && wb_adr_i == ADR_INTSTAT && wb_sel_i[0]) begin
			intStat_q <= (intStat_q & ~wb_dat_i[3:0]) | events;
		end else begin
			intStat_q <= intStat_q | events;
		end
	end

	// level interrupt from unmasked sticky bits
	// irq lags the status bit by one clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) irq <= 1'b0;
		else irq <= |(intStat_q & intMask_q);
	end
endmodule
`default_nettype wire

/* lcef_ctrl_props.sv */
// checker: bus, pull select, fault pin and interrupt relations of the led controller
`timescale 1ns/1ns
`default_nettype none
module lcef_ctrl_props
	import lcef_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        ledShort,
	input wire logic        ledOpen,
	input wire logic        thermalTrip,
	input wire logic        enPullUp,
	input wire logic        enPullDown,
	input wire logic        faultFlagNOut,
	input wire logic        faultFlagNOe,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a fresh request; the second edge of a held strobe is ignored by the slave
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic wrLo = req && wb_we_i && wb_sel_i[0]; // write reaching byte lane 0
	wire logic anyF = ledShort || ledOpen || thermalTrip;
	property p_ack_one;
		req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack not one pulse");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_zero;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
	property p_pull_excl;
		enPullUp != enPullDown;
	endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("pull select clash");
	// two edges allow for the control register and the registered pull select
	property p_pull_up;
		(wrLo && wb_adr_i == ADR_CTRL && wb_dat_i[CTRL_PULSE]) |=> ##2 enPullUp;
	endproperty
	a_pull_up: assert property (p_pull_up) else $error("no pull-up in pulse mode");
	property p_pull_dn;
		(wrLo && wb_adr_i == ADR_CTRL && !wb_dat_i[CTRL_PULSE]) |=> ##2 enPullDown;
	endproperty
	a_pull_dn: assert property (p_pull_dn) else $error("no pull-down in level mode");
	property p_fault_on;
		anyF [*6] |-> faultFlagNOe && !faultFlagNOut;
	endproperty
	a_fault_on: assert property (p_fault_on) else $error("fault pin not low");
	property p_fault_off;
		!anyF [*6] |-> !faultFlagNOe;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault pin low");
	property p_irq_mask;
		(wrLo && wb_adr_i == ADR_INTMASK && wb_dat_i[3:0] == 4'h0) |=> ##2 !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");
endmodule
bind lcef_ctrl lcef_ctrl_props u_props (.*);
`default_nettype wire

/* lcef_ctrl_tb.sv */
// testbench: bus, switch, ramp, dimming, fault and interrupt scenarios for the led controller
`timescale 1ns/1ns
`default_nettype none
module lcef_ctrl_tb;
	import lcef_pkg::*;
	logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, u;
	logic backlightEnable, ledShort, ledOpen, thermalTrip, fadeUpTimingGnd, fadeDownTimingGnd;
	logic mainEnableA, mainEnableB, mainOutputA, mainOutputB, backlightOutput, irq;
	logic enPullUp, enPullDown, faultFlagNOut, faultFlagNOe, closedA, closedB, faultLine;
	logic [6:0] pins; // output snapshot taken mid-cycle, away from the edge
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int hi; // high clocks counted over one pwm period
	// short filters and a one-clock pwm slot keep the run brief
	lcef_ctrl #(.DEB_CYC(8), .GLT_CYC(4), .PWM_CYC(3969)) u_dut (.*);
	lcef_switch_model u_sw (.*);
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	always @(negedge clk) pins <= {faultLine, irq, enPullDown, enPullUp, backlightOutput,
		mainOutputB, mainOutputA};
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// expected high clocks per pwm period: square law over the step
	function automatic int duty_exp(int lvl);
		return lvl * lvl;
	endfunction
	// clocks taken by a number of ramp steps at a given step register value
	function automatic int ramp_cyc(int steps, int iv);
		return steps * (iv + 1);
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic w(int n);
		repeat (n) @(posedge clk);
	endtask
	// one classic cycle; ack and data sampled at a rising edge, request released there
	task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
		int t;
		t = 0;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		if (t >= 50) chk("ack", 0, 1);
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk);
	endtask
	task automatic rc(string nm, logic [7:0] a, logic [31:0] m, logic [31:0] e);
		wb(0, a, 32'h0);
		chk(nm, rd & m, e);
	endtask
	task automatic press(bit b, int n);
		if (b) closedB <= 1;
		else closedA <= 1;
		w(n);
		closedA <= 0;
		closedB <= 0;
	endtask
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, closedA, closedB, backlightEnable, rst_n} = 0;
		{ledShort, ledOpen, thermalTrip, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
		{fadeUpTimingGnd, fadeDownTimingGnd} = 2'h3;
		void'($urandom(71278));
		w(20);
		rst_n <= 1;
		w(2);
		rc("ctrl", ADR_CTRL, 32'hFFFFFFFF, {30'h0, CTRL_RST});
		rc("fadeup", ADR_FADEUP, 32'hFFFFFFFF, {8'h0, FADEUP_RST});
		rc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
		chk("pullup", pins[4:3], 2'h1);
		u = $urandom_range(40, 90);
		wb(1, ADR_FADEUP, u);
		wb(1, ADR_FADEDN, u + 32'h11);
		rc("fadeup", ADR_FADEUP, 32'hFFFFFFFF, u);
		rc("fadedn", ADR_FADEDN, 32'hFFFFFFFF, u + 32'h11);
		// a blip shorter than the filter, then real presses with grounded timing pins
		press(0, 3);
		w(20);
		chk("blip", pins[0], 0);
		press(0, 20);
		w(20);
		chk("onA", pins[0], 1);
		rc("stOn", ADR_STATUS, 32'h1, 32'h1);
		press(0, 20);
		w(20);
		chk("offA", pins[0], 0);
		// full ramp of 63 steps, one per u+1 clocks
		{fadeUpTimingGnd, fadeDownTimingGnd} <= 2'h0;
		wb(1, ADR_INTSTAT, 32'hF);
		wb(1, ADR_INTMASK, 32'h2);
		press(0, 20);
		w(ramp_cyc(62, u) - 24);
		rc("rampBusy", ADR_STATUS, 32'h9, 32'h9);
		chk("irqEarly", pins[5], 0);
		w(ramp_cyc(2, u));
		rc("rampDone", ADR_STATUS, 32'h9, 32'h1);
		chk("fullA", pins[0], 1);
		chk("irqDone", pins[5], 1);
		wb(1, ADR_INTSTAT, 32'h2);
		w(2);
		chk("irqClr", pins[5], 0);
		// a second press mid fade-down turns the ramp round at once
		press(0, 20);
		w(200);
		rc("downBusy", ADR_STATUS, 32'h9, 32'h8);
		press(0, 20);
		w(600);
		rc("reversed", ADR_STATUS, 32'h9, 32'h1);
		chk("fullAgain", pins[0], 1);
		{fadeUpTimingGnd, fadeDownTimingGnd} <= 2'h3;
		press(0, 20);
		w(20);
		// level mode with a latched switch on channel b
		wb(1, ADR_CTRL, 32'h0);
		w(3);
		chk("pulldown", pins[4:3], 2'h2);
		closedB <= 1;
		w(20);
		chk("levelOn", pins[1], 1);
		closedB <= 0;
		w(20);
		chk("levelOff", pins[1], 0);
		// slow ramp on channel b: one step held over a whole pwm period
		{fadeUpTimingGnd, fadeDownTimingGnd} <= 2'h0;
		wb(1, ADR_FADEUP, 32'h00001F40);
		closedB <= 1;
		w(ramp_cyc(1, 32'h00001F40) + 100);
		hi = 0;
		repeat (int'(GAMMA_FULL)) begin
			@(posedge clk);
			hi += pins[1];
		end
		chk("duty", hi, duty_exp(1));
		closedB <= 0;
		w(200);
		chk("dutyOff", pins[1], 0);
		{fadeUpTimingGnd, fadeDownTimingGnd} <= 2'h3;
		// internal dimming: command on, pin press overrides it
		wb(1, ADR_CTRL, 32'h3);
		wb(1, ADR_CMD, 32'h1);
		w(4);
		chk("cmdOn", pins[0], 1);
		press(0, 20);
		w(20);
		chk("pinWins", pins[0], 0);
		// backlight: glitch ignored, level followed
		backlightEnable <= 1;
		w(2);
		backlightEnable <= 0;
		w(12);
		chk("blGlitch", pins[2], 0);
		backlightEnable <= 1;
		w(14);
		chk("blOn", pins[2], 1);
		backlightEnable <= 0;
		w(14);
		chk("blOff", pins[2], 0);
		// each fault source pulls the line low and shows in status
		wb(1, ADR_INTMASK, 32'h1);
		for (int i = 0; i < 3; i++) begin
			{thermalTrip, ledOpen, ledShort} <= 3'h1 << i;
			w(8);
			chk("faultLow", pins[6], 0);
			rc("faultSt", ADR_STATUS, 32'h1C0, 32'h40 << i);
			chk("faultIrq", pins[5], 1);
			{thermalTrip, ledOpen, ledShort} <= 3'h0;
			w(8);
			chk("faultHigh", pins[6], 1);
		end
		wb(1, ADR_INTMASK, 32'h0);
		w(3);
		chk("irqMasked", pins[5], 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* lcef_pkg.sv */
// package: register map, timing constants and carrier types for the led channel control
`default_nettype none
package lcef_pkg;
	// clock and timing
	localparam int CLK_HZ          = 50_000_000; // system clock rate
	localparam int DEBOUNCE_US     = 1000;       // main enable debounce time
	localparam int DEGLITCH_US     = 20;         // backlight enable deglitch time
	localparam int PWM_HZ          = 220;        // nominal internal pwm rate
	localparam int DEBOUNCE_CYC    = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	localparam int DEGLITCH_CYC    = (CLK_HZ / 1_000_000) * DEGLITCH_US;
	localparam int PWM_PERIOD_CYC  = CLK_HZ / PWM_HZ; // longest period, rounded down
	// fade ramp
	localparam logic [5:0]  STEP_FULL  = 6'h3F;    // 63 steps to full
	localparam logic [11:0] GAMMA_FULL = 12'hF81;  // duty of the last step (63*63)
	// register byte addresses
	localparam logic [7:0] ADR_CTRL    = 8'h00;
	localparam logic [7:0] ADR_CMD     = 8'h04;
	localparam logic [7:0] ADR_FADEUP  = 8'h08;
	localparam logic [7:0] ADR_FADEDN  = 8'h0C;
	localparam logic [7:0] ADR_CURRENT = 8'h10;
	localparam logic [7:0] ADR_STATUS  = 8'h14;
	localparam logic [7:0] ADR_INTSTAT = 8'h18;
	localparam logic [7:0] ADR_INTMASK = 8'h1C;
	// field positions
	localparam int CTRL_PULSE  = 0; // 1 = momentary switch, 0 = level switch
	localparam int CTRL_INTDIM = 1; // internal dimming mode
	localparam int ST_ON       = 0; // status [2:0] channel on state
	localparam int ST_BUSY     = 3; // status [5:3] ramp in progress
	localparam int ST_FAULT    = 6; // status [8:6] short, open, thermal
	localparam int ST_DB       = 9; // status [11:9] filtered enable levels
	localparam int INT_FAULT   = 0; // int [0] fault raised, [3:1] ramp done
	// reset values
	localparam logic [1:0]  CTRL_RST    = 2'h1;
	localparam logic [23:0] FADEUP_RST  = 24'h00C350;
	localparam logic [23:0] FADEDN_RST  = 24'h00C350;
	localparam logic [23:0] CURRENT_RST = 24'hFFFFFF;
	localparam logic [3:0]  INTMASK_RST = 4'h0;
	// carrier types
	typedef struct packed {
		logic intDim;
		logic pulseMode;
	} lcef_ctrl_t;
	typedef struct packed {
		logic thermal;
		logic open;
		logic short_;
	} lcef_fault_t;
endpackage
`default_nettype wire

/* lcef_switch_model.sv */
// partner: external switches on the main enables and the pull-up on the fault line
`timescale 1ns/1ns
`default_nettype none
module lcef_switch_model (
	input  wire logic closedA,      // switch a closed
	input  wire logic closedB,      // switch b closed
	input  wire logic enPullUp,     // device pull-up selected
	input  wire logic enPullDown,   // device pull-down selected
	input  wire logic faultFlagNOe, // device sinks the fault line
	output logic      mainEnableA,
	output logic      mainEnableB,
	output logic      faultLine
);
	// momentary switch grounds the pin, latched switch ties it high; open pin follows the pull
	assign mainEnableA = closedA ? enPullDown : enPullUp;
	assign mainEnableB = closedB ? enPullDown : enPullUp;
	// board pull-up wins only while nobody sinks the line
	assign faultLine = !faultFlagNOe;
endmodule
`default_nettype wire
